// *** gpio_data_direction_port.sv ***
/*
 * Seventeen-pin general purpose I/O port with APB register access:
 * input readback, output level latch, direction latch, and
 * write-one-to-set / write-one-to-clear companions for both latches.
 * Assumes one 100 MHz clock, an APB3 master without byte strobes,
 * pad inputs synchronous to core_clk, and pad cells that resolve the
 * pin wire from the level and the active-low enable.
 */
// Notes on behaviour
// - Low input word reads pins 0-15
// - High input word reads pin 16, rest zero
// - High output latch bit drives pin 16
// - Low output latch drives pins 0-15
// - Latch reads return latch, not pin level
// - High output-set one sets pin 16 latch
// - Low output-set ones set latch bits
// - Written zeros in set/clear change nothing
// - High output-clear one clears pin 16 latch
// - Low output-clear ones clear latch bits
// - High direction bit enables pin 16 driver
// - Low direction bits enable pins 0-15 drivers
// - High direction-set one enables pin 16
// - Low direction-set ones enable drivers
// - High direction-clear one disables pin 16
// - Low direction-clear ones disable drivers
`timescale 1ns/1ns

module gpio_data_direction_port
    import gpio_port_pkg::*;
(
    core_clk,
    rst_b,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    pin_in,
    pad_drive
);

`include "gpio_port_defines.svh"

    // =================================================================
    // Ports
    input  wire logic                      core_clk;  // 100 MHz clock
    input  wire logic                      rst_b;     // Async reset
    input  wire logic                      psel;      // APB select
    input  wire logic                      penable;   // APB access
    input  wire logic                      pwrite;    // APB direction
    input  wire logic [31:0]               paddr;     // Byte address
    input  wire logic [31:0]               pwdata;    // Write data
    output      logic [31:0]               prdata;    // Read data
    output      logic                      pready;    // Always ready
    output      logic                      pslverr;   // Unmapped access

    input  wire logic [`PIN_COUNT-1:0]     pin_in;    // Pad levels
    output      gpio_port_pkg::pad_drive_type pad_drive; // Pad drive

    // =================================================================
    // Functions

    // Byte address of a word index; upper bits must be zero so that
    // aliases further up the address space never hit a register
    function automatic logic [31:0] byte_addr(input logic [15:0] idx);
        byte_addr = {`ADDR_UPPER_ZERO, idx, `ADDR_LSB_ZERO};
    endfunction

    // Apply write-one-to-set and write-one-to-clear to a latch word;
    // zero bits of either mask leave the latch bit as it was
    function automatic logic [`WORD_MSB:0] set_clear(
        input logic [`WORD_MSB:0] cur,
        input logic [`WORD_MSB:0] set_mask,
        input logic [`WORD_MSB:0] clr_mask
    );
        set_clear = (cur | set_mask) & ~clr_mask;
    endfunction

    // =================================================================
    // Declarations
    pin_word_type       level_q;       // Output level latch
    pin_word_type       level_d;       // Next output level latch
    pin_word_type       enable_q;      // Direction latch, 1 = drive
    pin_word_type       enable_d;      // Next direction latch

    pin_word_type       sampled_q;     // Pad levels, one stage

    logic [31:0]        rdata_d;       // Read mux result
    logic [31:0]        prdata_q;      // Registered read data
    logic               err_d;         // Address not mapped
    logic               pslverr_q;     // Registered error answer

    logic               setup_phase;   // First cycle of a transfer
    logic               wr_strobe;     // Write takes effect now
    logic [`WORD_MSB:0] wdata16;       // Data lanes that matter

    logic               hit_lvl_h;     // Decode: high output latch
    logic               hit_lvl_l;     // Decode: low output latch
    logic               hit_lvl_sh;    // Decode: high output set
    logic               hit_lvl_sl;    // Decode: low output set
    logic               hit_lvl_ch;    // Decode: high output clear
    logic               hit_lvl_cl;    // Decode: low output clear
    logic               hit_en_h;      // Decode: high direction
    logic               hit_en_l;      // Decode: low direction
    logic               hit_en_sh;     // Decode: high direction set
    logic               hit_en_sl;     // Decode: low direction set
    logic               hit_en_ch;     // Decode: high direction clear
    logic               hit_en_cl;     // Decode: low direction clear

    // =================================================================
    // Bus phases
    // Setup cycle prepares the read answer; the access cycle that
    // follows carries the write, so a write lands exactly once.
    assign setup_phase = psel & ~penable;
    assign wr_strobe   = psel & penable & pwrite;
    assign wdata16     = pwdata[`WORD_MSB:0];

    // Zero wait states: every access completes in its first access
    // cycle, which keeps the port cheap and the timing fixed
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // =================================================================
    // Write address decode
    // Only the access cycle of a write raises a hit.
    always_comb begin
        hit_lvl_h  = 1'b0;
        hit_lvl_l  = 1'b0;
        hit_lvl_sh = 1'b0;
        hit_lvl_sl = 1'b0;
        hit_lvl_ch = 1'b0;
        hit_lvl_cl = 1'b0;
        hit_en_h   = 1'b0;
        hit_en_l   = 1'b0;
        hit_en_sh  = 1'b0;
        hit_en_sl  = 1'b0;
        hit_en_ch  = 1'b0;
        hit_en_cl  = 1'b0;

        if (!wr_strobe) begin
            // No write this cycle
            hit_lvl_h = 1'b0;
        end else if (paddr == byte_addr(`IDX_DRIVE_LEVEL_HIGH)) begin
            // Pin 16 level
            hit_lvl_h = 1'b1;
        end else if (paddr == byte_addr(`IDX_DRIVE_LEVEL_LOW)) begin
            // Low word level
            hit_lvl_l = 1'b1;
        end else if (paddr == byte_addr(`IDX_DRIVE_RAISE_HIGH)) begin
            // Pin 16 raise
            hit_lvl_sh = 1'b1;
        end else if (paddr == byte_addr(`IDX_DRIVE_RAISE_LOW)) begin
            // Low word raise
            hit_lvl_sl = 1'b1;
        end else if (paddr == byte_addr(`IDX_DRIVE_LOWER_HIGH)) begin
            // Pin 16 lower
            hit_lvl_ch = 1'b1;
        end else if (paddr == byte_addr(`IDX_DRIVE_LOWER_LOW)) begin
            // Low word lower
            hit_lvl_cl = 1'b1;
        end else if (paddr == byte_addr(`IDX_ENABLE_HIGH)) begin
            // Pin 16 enable
            hit_en_h = 1'b1;
        end else if (paddr == byte_addr(`IDX_ENABLE_LOW)) begin
            // Low word enable
            hit_en_l = 1'b1;
        end else if (paddr == byte_addr(`IDX_ENABLE_RAISE_HIGH)) begin
            // Pin 16 enable on
            hit_en_sh = 1'b1;
        end else if (paddr == byte_addr(`IDX_ENABLE_RAISE_LOW)) begin
            // Low word enable on
            hit_en_sl = 1'b1;
        end else if (paddr == byte_addr(`IDX_ENABLE_LOWER_HIGH)) begin
            // Pin 16 enable off
            hit_en_ch = 1'b1;
        end else if (paddr == byte_addr(`IDX_ENABLE_LOWER_LOW)) begin
            // Low word enable off
            hit_en_cl = 1'b1;
        end else begin
            // Read-only or unmapped: write ignored
            hit_lvl_h = 1'b0;
        end
    end

    // =================================================================
    // Output level latch, next value
    // Direct writes replace; set and clear only touch written ones.
    always_comb begin
        level_d = level_q;

        if (hit_lvl_l) begin
            // Replace word
            level_d.low = wdata16;
        end else if (hit_lvl_sl) begin
            // Set written ones
            level_d.low = set_clear(level_q.low, wdata16,
                                    `LOW_RESET);
        end else if (hit_lvl_cl) begin
            // Clear written ones
            level_d.low = set_clear(level_q.low, `LOW_RESET,
                                    wdata16);
        end

        // High bit: only bit 0 of the written word counts
        if (hit_lvl_h) begin
            // Replace bit
            level_d.high = wdata16[`HIGH_BIT];
        end else if (hit_lvl_sh && wdata16[`HIGH_BIT]) begin
            // Set pin 16
            level_d.high = 1'b1;
        end else if (hit_lvl_ch && wdata16[`HIGH_BIT]) begin
            // Clear pin 16
            level_d.high = 1'b0;
        end
    end

    // =================================================================
    // Direction latch, next value
    always_comb begin
        enable_d = enable_q;

        if (hit_en_l) begin
            // Replace word
            enable_d.low = wdata16;
        end else if (hit_en_sl) begin
            // Drivers on
            enable_d.low = set_clear(enable_q.low, wdata16,
                                     `LOW_RESET);
        end else if (hit_en_cl) begin
            // Drivers off
            enable_d.low = set_clear(enable_q.low, `LOW_RESET,
                                     wdata16);
        end

        // High bit: a written zero in set or clear does nothing
        if (hit_en_h) begin
            // Replace bit
            enable_d.high = wdata16[`HIGH_BIT];
        end else if (hit_en_sh && wdata16[`HIGH_BIT]) begin
            // Pin 16 driver on
            enable_d.high = 1'b1;
        end else if (hit_en_ch && wdata16[`HIGH_BIT]) begin
            // Pin 16 driver off
            enable_d.high = 1'b0;
        end
    end

    // =================================================================
    // Output level latch register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Nothing driven high
            level_q.low  <= `LOW_RESET;
            level_q.high <= `HIGH_RESET;
        end else begin
            // Next latch value
            level_q <= level_d;
        end
    end

    // =================================================================
    // Direction latch register
    // Zero at reset so no pin fights the board before software runs.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Every driver off
            enable_q.low  <= `LOW_RESET;
            enable_q.high <= `HIGH_RESET;
        end else begin
            // Next latch value
            enable_q <= enable_d;
        end
    end

    // =================================================================
    // Pad sampling
    // Inputs are synchronous to core_clk; one stage gives the read
    // path a clean flop source. The readback lags the pad by a cycle.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Pads read low
            sampled_q.low  <= `LOW_RESET;
            sampled_q.high <= `HIGH_RESET;
        end else begin
            // Fresh pad sample
            sampled_q.low  <= pin_in[`LOW_MSB:0];
            sampled_q.high <= pin_in[`HIGH_PIN];
        end
    end

    // =================================================================
    // Read mux
    // Latch registers return the latch, never the pad, so a pin held
    // by the board may read differently from its latch.
    always_comb begin
        rdata_d = `ZERO_WORD;
        err_d   = 1'b0;

        if (paddr == byte_addr(`IDX_PIN_LEVEL_LOW)) begin
            // Pads 0 to 15
            rdata_d = {`ZERO_BUS_FILL, sampled_q.low};
        end else if (paddr == byte_addr(`IDX_PIN_LEVEL_HIGH)) begin
            // Pad 16 alone
            rdata_d = {`ZERO_BUS_FILL, `ZERO_HIGH_FILL,
                       sampled_q.high};
        end else if (paddr == byte_addr(`IDX_DRIVE_LEVEL_LOW)) begin
            // Level latch
            rdata_d = {`ZERO_BUS_FILL, level_q.low};
        end else if (paddr == byte_addr(`IDX_DRIVE_LEVEL_HIGH)) begin
            // Level bit
            rdata_d = {`ZERO_BUS_FILL, `ZERO_HIGH_FILL,
                       level_q.high};
        end else if (paddr == byte_addr(`IDX_ENABLE_LOW)) begin
            // Enable latch
            rdata_d = {`ZERO_BUS_FILL, enable_q.low};
        end else if (paddr == byte_addr(`IDX_ENABLE_HIGH)) begin
            // Enable bit
            rdata_d = {`ZERO_BUS_FILL, `ZERO_HIGH_FILL,
                       enable_q.high};
        end else if (paddr == byte_addr(`IDX_DRIVE_RAISE_HIGH) ||
                     paddr == byte_addr(`IDX_DRIVE_RAISE_LOW)  ||
                     paddr == byte_addr(`IDX_DRIVE_LOWER_HIGH) ||
                     paddr == byte_addr(`IDX_DRIVE_LOWER_LOW)) begin
            // Level companions
            rdata_d = `ZERO_WORD;
        end else if (paddr == byte_addr(`IDX_ENABLE_RAISE_HIGH) ||
                     paddr == byte_addr(`IDX_ENABLE_RAISE_LOW)  ||
                     paddr == byte_addr(`IDX_ENABLE_LOWER_HIGH) ||
                     paddr == byte_addr(`IDX_ENABLE_LOWER_LOW)) begin
            // Enable companions
            rdata_d = `ZERO_WORD;
        end else begin
            // Unmapped: read zero and flag the error
            err_d = 1'b1;
        end
    end

    // =================================================================
    // Answer registers
    // Captured in the setup cycle; the access cycle only presents
    // them, so prdata and pslverr come straight from flops. No write
    // can land between setup and access of the same transfer.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Quiet bus answer
            prdata_q  <= `ZERO_WORD;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            // Writes read back as zero data
            prdata_q  <= pwrite ? `ZERO_WORD : rdata_d;
            pslverr_q <= err_d;
        end
    end

    // =================================================================
    // Pad drive
    // Enable is active low at the pad; a clear direction bit leaves
    // the pin floating for the board to set.
    always_comb begin
        // Latch straight out
        pad_drive.level = {level_q.high, level_q.low};
        // Inverted direction
        pad_drive.oe_b  = ~{enable_q.high, enable_q.low};
    end

endmodule

// *** gpio_port_defines.svh ***
/*
 * Register indices, field layout and reset values of the GPIO port.
 * Assumes inclusion by bare name from the package and the port module.
 */
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// =====================================================================
// Word indices (byte address is four times the index)
`define IDX_PIN_LEVEL_HIGH        16'h4700
`define IDX_PIN_LEVEL_LOW         16'h4702
`define IDX_DRIVE_LEVEL_HIGH      16'h4704
`define IDX_DRIVE_LEVEL_LOW       16'h4706
`define IDX_DRIVE_RAISE_HIGH      16'h4708
`define IDX_DRIVE_RAISE_LOW       16'h470A
`define IDX_DRIVE_LOWER_HIGH      16'h470C
`define IDX_DRIVE_LOWER_LOW       16'h470E
`define IDX_ENABLE_HIGH           16'h4714
`define IDX_ENABLE_LOW            16'h4716
`define IDX_ENABLE_RAISE_HIGH     16'h4718
`define IDX_ENABLE_RAISE_LOW      16'h471A
`define IDX_ENABLE_LOWER_HIGH     16'h471C
`define IDX_ENABLE_LOWER_LOW      16'h471E

// =====================================================================
// Field layout
`define PIN_COUNT                 17
`define LOW_MSB                   15
`define HIGH_PIN                  16
`define HIGH_BIT                  0
`define WORD_MSB                  15
`define ADDR_LSB_ZERO             2'b00
`define ADDR_UPPER_ZERO           14'h0000

// =====================================================================
// Reset and fixed values
`define LOW_RESET                 16'h0000
`define HIGH_RESET                1'b0
`define ZERO_WORD                 32'h0000_0000
`define ZERO_HIGH_FILL            15'h0000
`define ZERO_BUS_FILL             16'h0000

`endif

// *** gpio_port_pkg.sv ***
/*
 * Types shared by the GPIO port and its surroundings.
 * Assumes gpio_port_defines.svh sits in the include path.
 */
package gpio_port_pkg;

`include "gpio_port_defines.svh"

    // =================================================================
    // Pad-side drive bundle: level and active-low output enable
    typedef struct packed {
        logic [`PIN_COUNT-1:0] level;   // Level driven when enabled
        logic [`PIN_COUNT-1:0] oe_b;    // Low while the pin is driven
    } pad_drive_type;

    // One low word plus the single high bit, as software sees them
    typedef struct packed {
        logic                  high;    // Pin 16
        logic [`LOW_MSB:0]     low;     // Pins 0 to 15
    } pin_word_type;

endpackage

// *** gpio_port_monitor.sv ***
/*
 * Checker for the GPIO port: latch updates, readback, reset state.
 * Assumes it is bound to gpio_data_direction_port, byte address
 * equal to four times the register index.
 */
`timescale 1ns/1ns
module gpio_port_monitor (
    input wire logic                        core_clk,
    input wire logic                        rst_b,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [31:0]                 paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [16:0]                 pin_in,
    input wire gpio_port_pkg::pad_drive_type pad_drive
);
    import gpio_port_pkg::*;
    // =================================================================
    // Phase decode
    logic wr_acc;   // Write in its access phase
    logic rd_set;   // Read in its setup phase
    assign wr_acc = psel && penable && pwrite;
    assign rd_set = psel && !penable && !pwrite;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // =================================================================
    // Latch behaviour
    a_low_write: assert property (
        wr_acc && paddr == 32'h0001_1C18 |=>
        pad_drive.level[15:0] == $past(pwdata[15:0]))
        else $error("low level latch not loaded");
    a_high_write: assert property (
        wr_acc && paddr == 32'h0001_1C10 |=>
        pad_drive.level[16] == $past(pwdata[0]))
        else $error("high level latch not loaded");
    a_level_raise: assert property (
        wr_acc && paddr == 32'h0001_1C28 |=> pad_drive.level[15:0] ==
        ($past(pad_drive.level[15:0]) | $past(pwdata[15:0])))
        else $error("level set wrong");
    a_level_lower: assert property (
        wr_acc && paddr == 32'h0001_1C38 |=> pad_drive.level[15:0] ==
        ($past(pad_drive.level[15:0]) & ~$past(pwdata[15:0])))
        else $error("level clear wrong");
    a_high_raise: assert property (
        wr_acc && paddr == 32'h0001_1C20 && pwdata[0] |=>
        pad_drive.level[16]) else $error("high level set wrong");
    a_high_lower: assert property (
        wr_acc && paddr == 32'h0001_1C30 && pwdata[0] |=>
        !pad_drive.level[16]) else $error("high level clear wrong");
    a_dir_raise: assert property (
        wr_acc && paddr == 32'h0001_1C68 |=> pad_drive.oe_b[15:0] ==
        ($past(pad_drive.oe_b[15:0]) & ~$past(pwdata[15:0])))
        else $error("enable set wrong");
    a_dir_lower: assert property (
        wr_acc && paddr == 32'h0001_1C78 |=> pad_drive.oe_b[15:0] ==
        ($past(pad_drive.oe_b[15:0]) | $past(pwdata[15:0])))
        else $error("enable clear wrong");
    a_dir_high_on: assert property (
        wr_acc && paddr == 32'h0001_1C60 && pwdata[0] |=>
        !pad_drive.oe_b[16]) else $error("high enable set wrong");
    a_dir_high_off: assert property (
        wr_acc && paddr == 32'h0001_1C70 && pwdata[0] |=>
        pad_drive.oe_b[16]) else $error("high enable clear wrong");
    // Without a write the pads never move on their own
    a_quiet_hold: assert property (
        !wr_acc |=> $stable(pad_drive)) else $error("pads moved");
    // =================================================================
    // Readback and reset
    a_latch_read: assert property (
        rd_set && paddr == 32'h0001_1C18 |=>
        prdata == {16'h0000, $past(pad_drive.level[15:0])})
        else $error("latch readback wrong");
    // One sample stage, then capture at the setup edge
    a_pin_read: assert property (
        rd_set && paddr == 32'h0001_1C08 |=>
        prdata[15:0] == $past(pin_in[15:0], 2))
        else $error("pin readback wrong");
    a_reset_idle: assert property (disable iff (1'b0)
        !rst_b && !$past(rst_b) |->
        pad_drive.oe_b == 17'h1FFFF && pad_drive.level == 17'h0)
        else $error("pads driven in reset");
endmodule

bind gpio_data_direction_port gpio_port_monitor gpio_port_monitor_inst (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pad_drive(pad_drive));

// *** pin_board_model.sv ***
/*
 * Board around the pins: a pin follows the chip while its driver is
 * on, otherwise whatever the board puts there (ext_level).
 * Assumes the bench moves ext_level so a stale value never passes.
 */
`timescale 1ns/1ns
module pin_board_model (
    input wire gpio_port_pkg::pad_drive_type pad_drive,
    input wire logic [16:0]                 ext_level,
    output     logic [16:0]                 pin_in
);
    import gpio_port_pkg::*;
    // =================================================================
    // Wire resolution; active-low enable selects the chip's level
    assign pin_in = (pad_drive.oe_b & ext_level)
                  | (~pad_drive.oe_b & pad_drive.level);
endmodule

// *** tb_gpio_data_direction_port.sv ***
/*
 * Self-checking bench for the GPIO port over APB.
 * Assumes zero-wait APB slave and byte address = 4 * index.
 */
`timescale 1ns/1ns
module tb_gpio_data_direction_port;
    import gpio_port_pkg::*;
    logic          core_clk;
    logic          rst_b;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [31:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [16:0]   pin_in;
    logic [16:0]   ext_level;   // Board level on undriven pins
    pad_drive_type pad_drive;
    int            err_total;
    int            compares;

    gpio_data_direction_port gpio_data_direction_port_inst (
        .core_clk(core_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pad_drive(pad_drive));
    pin_board_model pin_board_model_inst (.pad_drive(pad_drive),
        .ext_level(ext_level), .pin_in(pin_in));

    always #5 core_clk = ~core_clk;

    // =================================================================
    // Helpers
    function automatic logic [31:0] ba(input logic [15:0] idx);
        return {14'h0000, idx, 2'b00};
    endfunction

    task automatic check_word(input logic [31:0] got, input logic [31:0] e);
        compares++;
        if (got !== e) begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, got, e);
        end
    endtask

    task automatic check_pins(input pad_drive_type got, input pad_drive_type e);
        compares++;
        if (got !== e) begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, got, e);
        end
    endtask

    // One APB transfer; request held until pready is seen high or 64 access cycles pass
    task automatic apb(input logic [31:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) err_total++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(a, 1'b1, d, rd, err);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
                          input logic eerr);
        logic [31:0] rd;
        logic        err;
        apb(a, 1'b0, 32'h0, rd, err);
        check_word(rd, e);
        check_word({31'h0, err}, {31'h0, eerr});
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // =================================================================
    // Scenarios
    task automatic t_reset_values;
        logic [15:0] regs [12] = '{16'h4704, 16'h4706, 16'h4708,
            16'h470A, 16'h470C, 16'h470E, 16'h4714, 16'h4716,
            16'h4718, 16'h471A, 16'h471C, 16'h471E};
        check_pins(pad_drive, {17'h00000, 17'h1FFFF});
        foreach (regs[i]) rd_chk(ba(regs[i]), 32'h0, 1'b0);
        rd_chk(ba(16'h4710), 32'h0, 1'b1);
    endtask

    task automatic t_inputs;
        ext_level <= 17'h1A5C3;
        @(posedge core_clk);
        rd_chk(ba(16'h4702), 32'hA5C3, 1'b0);
        rd_chk(ba(16'h4700), 32'h1, 1'b0);
        ext_level <= 17'h05A3C;
        @(posedge core_clk);
        rd_chk(ba(16'h4702), 32'h5A3C, 1'b0);
        rd_chk(ba(16'h4700), 32'h0, 1'b0);
    endtask

    task automatic t_drive_level;
        wr(ba(16'h4706), 32'hFFFF3C96);
        rd_chk(ba(16'h4706), 32'h3C96, 1'b0);
        wr(ba(16'h4704), 32'h0000FFFF);
        rd_chk(ba(16'h4704), 32'h1, 1'b0);
        wr(ba(16'h470A), 32'h4001);
        rd_chk(ba(16'h4706), 32'h7C97, 1'b0);
        wr(ba(16'h470E), 32'h0882);
        rd_chk(ba(16'h4706), 32'h7415, 1'b0);
        wr(ba(16'h470C), 32'h1);
        rd_chk(ba(16'h4704), 32'h0, 1'b0);
        wr(ba(16'h4708), 32'h1);
        wr(ba(16'h4708), 32'h0);
        rd_chk(ba(16'h4704), 32'h1, 1'b0);
        rd_chk(ba(16'h470A), 32'h0, 1'b0);
        check_pins(pad_drive, {17'h17415, 17'h1FFFF});
        rd_chk(ba(16'h4702), 32'h5A3C, 1'b0);
        rd_chk(ba(16'h4706) | 32'h1, 32'h0, 1'b1);
    endtask

    task automatic t_direction;
        wr(ba(16'h4716), 32'h00FF);
        rd_chk(ba(16'h4716), 32'h00FF, 1'b0);
        wr(ba(16'h471A), 32'hF000);
        rd_chk(ba(16'h4716), 32'hF0FF, 1'b0);
        wr(ba(16'h471E), 32'h0F0F);
        rd_chk(ba(16'h4716), 32'hF0F0, 1'b0);
        wr(ba(16'h4714), 32'hFFFF);
        rd_chk(ba(16'h4714), 32'h1, 1'b0);
        wr(ba(16'h471C), 32'h1);
        rd_chk(ba(16'h4714), 32'h0, 1'b0);
        wr(ba(16'h4718), 32'h1);
        rd_chk(ba(16'h4714), 32'h1, 1'b0);
        check_pins(pad_drive, {17'h17415, 17'h00F0F});
        rd_chk(ba(16'h4702), 32'h7A1C, 1'b0);
        rd_chk(ba(16'h4700), 32'h1, 1'b0);
        wr(ba(16'h470C), 32'h1);
        rd_chk(ba(16'h4700), 32'h0, 1'b0);
    endtask

    // =================================================================
    // Main sequence and watchdog
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        ext_level = 17'h0A55A;
        err_total = 0;
        compares = 0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset_values;
        t_inputs;
        t_drive_level;
        t_direction;
        // Second reset mid-run must undrive every pin again
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset_values;
        report_and_stop;
    end

    initial begin
        #100000;
        err_total++;
        report_and_stop;
    end
endmodule
